// >>> core/sar_adc_pkg.sv
package sar_adc_pkg;

  // internal bus addresses of the converter registers
  localparam logic [15:0] ADDR_RESULT_LO = 16'hFF0E;  // result, low byte / word access
  localparam logic [15:0] ADDR_RESULT_HI = 16'hFF0F;  // result, high byte
  localparam logic [15:0] ADDR_MODE      = 16'hFF80;  // converter_mode
  localparam logic [15:0] ADDR_CHAN      = 16'hFF81;  // channel_select_reg

  // reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [2:0]  CHAN_RST   = 3'h0;

  // converter_mode bit positions
  localparam int MODE_RUN_BIT     = 7;
  localparam int MODE_SRC_BIT     = 6;
  localparam int MODE_TIME_LSB    = 3;
  localparam int MODE_EDGE_LSB    = 1;
  localparam int MODE_BOOSTER_BIT = 0;

  // result layout: 10-bit value left-justified, low six bits zero
  localparam int RES_BITS     = 10;
  localparam int RES_PAD_BITS = 6;
  localparam int NUM_INPUTS   = 8;

  // trigger edge encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // conversion-time codes
  localparam logic [2:0] TIME_144 = 3'h0;
  localparam logic [2:0] TIME_120 = 3'h1;
  localparam logic [2:0] TIME_96  = 3'h2;
  localparam logic [2:0] TIME_576 = 3'h4;
  localparam logic [2:0] TIME_480 = 3'h5;
  localparam logic [2:0] TIME_384 = 3'h6;

  // a conversion is split into periods: two sample periods, one per result bit
  localparam int SAMPLE_PERIODS = 2;
  localparam int CONV_PERIODS   = SAMPLE_PERIODS + RES_BITS;

  // conversion lengths in main clock cycles, and the period length derived from each
  localparam int CONV_CYC_144 = 144;
  localparam int CONV_CYC_120 = 120;
  localparam int CONV_CYC_96  = 96;
  localparam int CONV_CYC_576 = 576;
  localparam int CONV_CYC_480 = 480;
  localparam int CONV_CYC_384 = 384;
  localparam logic [7:0] PER_144 = 8'(CONV_CYC_144 / CONV_PERIODS);
  localparam logic [7:0] PER_120 = 8'(CONV_CYC_120 / CONV_PERIODS);
  localparam logic [7:0] PER_96  = 8'(CONV_CYC_96 / CONV_PERIODS);
  localparam logic [7:0] PER_576 = 8'(CONV_CYC_576 / CONV_PERIODS);
  localparam logic [7:0] PER_480 = 8'(CONV_CYC_480 / CONV_PERIODS);
  localparam logic [7:0] PER_384 = 8'(CONV_CYC_384 / CONV_PERIODS);

  // converter_mode as a packed record, msb first
  typedef struct packed {
    logic       run;
    logic       start_src;
    logic [2:0] conv_time;
    logic [1:0] trig_edge;
    logic       booster;
  } mode_t;

  // controller states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_t;

endpackage

// >>> core/trig_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module trig_edge_detect
  import sar_adc_pkg::*;
(
  input  wire logic       clk,       // main clock
  input  wire logic       rst_n,     // synchronised reset
  input  wire logic       pin_in,    // asynchronous trigger pin
  input  wire logic [1:0] edge_sel,  // edge selection code
  output logic            hit        // one-cycle pulse on a selected edge
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  always_comb begin
    case (edge_sel)
      EDGE_FALL: hit = prev_r & ~sync_r;
      EDGE_RISE: hit = ~prev_r & sync_r;
      EDGE_BOTH: hit = prev_r ^ sync_r;
      default:   hit = 1'b0;
    endcase
  end
endmodule // trig_edge_detect
`default_nettype wire

// >>> core/sar_adc_control.sv
// Function
// - eight inputs, one per conversion, 10-bit result
// - edge field: none, falling, rising, both
// - hardware mode: one conversion, interrupt, wait trigger
// - software mode: convert back to back while running
// - interrupt once at every conversion end
// - approximation msb first, copy at lsb
// - 16-bit result, left-justified, low six zero
// - high eight bits in high byte
// - reset clears result to zero
// - mode register byte/bit writable, resets zero
// - mode bit 7 is run control
// - mode bit 6 selects start source
// - time field sets conversion length in cycles
// - bit 0 enables booster, software waits
// - run and start source bits select state
// - sample input at start, hold afterwards
// - channel register three bits, resets zero
// - mode/channel write aborts, restarts if running in software mode
// - hardware mode channel write waits new trigger
// - clearing run stops conversion at once
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control
  import sar_adc_pkg::*;
(
  input  wire logic        CLOCK,        // main system clock
  input  wire logic        RST_N,        // asynchronous active-low reset
  input  wire logic [15:0] BUS_ADDR,     // internal bus address
  input  wire logic        BUS_WR,       // 8-bit write strobe
  input  wire logic [7:0]  BUS_WDATA,    // 8-bit write data
  input  wire logic        BUS_BIT_WR,   // single-bit write strobe
  input  wire logic [2:0]  BUS_BIT_IDX,  // bit number for a bit write
  input  wire logic        BUS_BIT_VAL,  // value for a bit write
  input  wire logic        BUS_RD,       // read strobe
  output logic [15:0]      BUS_RDATA,    // read data, one cycle after strobe
  output logic             BUS_RVALID,   // read data valid pulse
  input  wire logic        EXT_TRIG_IN,  // external trigger pin
  input  wire logic        CMP_IN,       // comparator: input at or above tap
  output logic [2:0]       ANALOG_SEL,   // input selector to the sampler
  output logic             SAMPLE_EN,    // high: sampler tracks, low: holds
  output logic [9:0]       TAP_CODE,     // trial code for the resistor string
  output logic             BOOSTER_EN,   // reference booster enable
  output logic             CONVERTING,   // conversion running
  output logic             CONV_DONE_IRQ // end-of-conversion pulse
);

  logic        rst_meta_r;
  logic        rst_n_r;
  logic        cmp_meta_r;
  logic        cmp_sync_r;
  mode_t       mode_r;
  mode_t       mode_nxt;
  logic [2:0]  chan_r;
  logic [15:0] result_r;
  logic [9:0]  sar_r;
  conv_state_t state_r;
  conv_state_t state_nxt;
  logic [7:0]  per_len_r;
  logic [7:0]  tick_r;
  logic [3:0]  period_r;
  logic [2:0]  conv_chan_r;
  logic [7:0]  per_len_sel;
  logic        mode_wr;
  logic        chan_wr;
  logic        any_wr;
  logic        trig_hit;
  logic        period_end;
  logic        last_bit;
  logic        conv_end;
  logic        start_conv;
  logic [3:0]  bit_idx;
  logic [15:0] rdata_nxt;

  // reset release through two flops, assertion stays asynchronous
  // the release is synchronous, so no flop sees reset lift near an edge
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // comparator output is analog-timed, so synchronise it
  // costs two cycles of lag, well inside the shortest bit period
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
    end else begin
      cmp_meta_r <= CMP_IN;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  // write decode; only the mode register takes bit writes
  // channel bits 7:3 are not stored, so a bit write there has nothing to hit
  assign mode_wr = (BUS_WR | BUS_BIT_WR) && (BUS_ADDR == ADDR_MODE);
  assign chan_wr = BUS_WR && (BUS_ADDR == ADDR_CHAN);
  assign any_wr  = mode_wr | chan_wr;

  // next mode value for byte or bit write
  // a bit write changes one field, the others keep their value
  always_comb begin
    mode_nxt = mode_r;
    if (BUS_WR && BUS_ADDR == ADDR_MODE) begin
      mode_nxt = mode_t'(BUS_WDATA);
    end else if (BUS_BIT_WR && BUS_ADDR == ADDR_MODE) begin
      mode_nxt[BUS_BIT_IDX] = BUS_BIT_VAL;
    end
  end

  // mode register
  // written whole by a byte write, one bit at a time by a bit write
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= mode_t'(MODE_RST);
    end else if (mode_wr) begin
      mode_r <= mode_nxt;
    end
  end

  // channel register, three low bits only
  // upper bits are not kept and read back as zero
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      chan_r <= CHAN_RST;
    end else if (chan_wr) begin
      chan_r <= BUS_WDATA[2:0];
    end
  end

  // external trigger, synchronised and edge-qualified
  // a new edge code takes effect the cycle after its write
  trig_edge_detect u_trig (
    .clk      (CLOCK),
    .rst_n    (rst_n_r),
    .pin_in   (EXT_TRIG_IN),
    .edge_sel (mode_r.trig_edge),
    .hit      (trig_hit)
  );

  // period length from the conversion-time code
  // the length is frozen at start, so a later time write cannot stretch a period
  always_comb begin
    case (mode_nxt.conv_time)
      TIME_144: per_len_sel = PER_144;
      TIME_120: per_len_sel = PER_120;
      TIME_96:  per_len_sel = PER_96;
      TIME_576: per_len_sel = PER_576;
      TIME_480: per_len_sel = PER_480;
      TIME_384: per_len_sel = PER_384;
      default:  per_len_sel = PER_144; // prohibited codes fall back to the 144-cycle length
    endcase
  end

  // period and bit bookkeeping
  assign period_end = (tick_r == per_len_r - 8'h01);
  assign bit_idx    = 4'(CONV_PERIODS - 1) - period_r;
  assign last_bit   = (period_r == 4'(CONV_PERIODS - 1));
  assign conv_end   = (state_r == ST_CONVERT) && period_end && last_bit;

  // run and start source bits pick stop, wait or convert
  // any mode or channel write aborts; with the run bit set, software mode restarts from the top and hardware mode rearms
  always_comb begin
    state_nxt  = state_r;
    start_conv = 1'b0;
    if (any_wr) begin
      // a write in the final cycle wins over the result store
      // run bit clear stops everything
      // start source picks armed or sampling
      if (!mode_nxt.run) begin
        state_nxt = ST_IDLE;
      end else if (mode_nxt.start_src) begin
        // hardware mode waits for a fresh edge
        state_nxt = ST_ARMED;
      end else begin
        state_nxt  = ST_SAMPLE;
        start_conv = 1'b1;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_IDLE;
        end
        ST_ARMED: begin
          // edges are only accepted while armed, never mid-conversion
          if (trig_hit) begin
            state_nxt  = ST_SAMPLE;
            start_conv = 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (period_end && period_r == 4'(SAMPLE_PERIODS - 1)) begin
            state_nxt = ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (conv_end) begin
            if (mode_r.start_src) begin
              state_nxt = ST_ARMED;
            end else begin
              // software mode runs back to back
              state_nxt  = ST_SAMPLE;
              start_conv = 1'b1;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // controller state
  // one register; every decision is made in the comb block above
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // timing counters; per_len_r is frozen for the whole conversion
  // outside a conversion the counters rest at zero, ready for a start
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_r    <= 8'h00;
      period_r  <= 4'h0;
      per_len_r <= PER_144;
    end else if (start_conv) begin
      tick_r    <= 8'h00;
      period_r  <= 4'h0;
      per_len_r <= per_len_sel;
    end else if (state_r == ST_SAMPLE || state_r == ST_CONVERT) begin
      if (period_end) begin
        tick_r   <= 8'h00;
        period_r <= period_r + 4'h1;
      end else begin
        tick_r <= tick_r + 8'h01;
      end
    end else begin
      tick_r   <= 8'h00;
      period_r <= 4'h0;
    end
  end

  // input choice latched at start, held all conversion
  // one channel of eight per conversion
  // a restarting channel write is taken at once, not a cycle late
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      conv_chan_r <= CHAN_RST;
    end else if (start_conv) begin
      conv_chan_r <= chan_wr ? BUS_WDATA[2:0] : chan_r;
    end
  end

  // trial bit set, kept or dropped, msb downward
  // an aborting write leaves sar_r alone; the restart reloads it
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sar_r <= 10'h000;
    end else if (state_r == ST_SAMPLE && !any_wr && state_nxt == ST_CONVERT) begin
      sar_r <= 10'h200;
    end else if (state_r == ST_CONVERT && period_end && !any_wr) begin
      // comparator sampled in the last cycle of the bit period, well past sync delay
      sar_r[bit_idx] <= cmp_sync_r;
      if (!last_bit) begin
        sar_r[bit_idx - 4'h1] <= 1'b1;
      end
    end
  end

  // copy on lsb decision, skipped if a write aborts
  // upper eight bits land in the high byte
  // reset clears the result
  // the lsb comes straight from the comparator, sar_r has not got it yet
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      result_r <= RESULT_RST;
    end else if (conv_end && !any_wr) begin
      result_r <= {sar_r[9:1], cmp_sync_r, {RES_PAD_BITS{1'b0}}};
    end
  end

  // pulse in the result load cycle
  // combinational, so it cannot outlast the single conv_end cycle
  always_comb begin
    CONV_DONE_IRQ = conv_end && !any_wr;
  end

  // read mux; the result word must be taken in one access
  // the high-byte address answers in the low bits for byte readers
  always_comb begin
    case (BUS_ADDR)
      ADDR_RESULT_LO: rdata_nxt = result_r;
      ADDR_RESULT_HI: rdata_nxt = {8'h00, result_r[15:8]};
      ADDR_MODE:      rdata_nxt = {8'h00, mode_r};
      ADDR_CHAN:      rdata_nxt = {13'h0000, chan_r};
      default:        rdata_nxt = 16'h0000;
    endcase
  end

  // registered read data
  // data holds until the next read, so a slow reader still sees it
  always_ff @(posedge CLOCK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      BUS_RDATA  <= 16'h0000;
      BUS_RVALID <= 1'b0;
    end else begin
      BUS_RVALID <= BUS_RD;
      if (BUS_RD) begin
        BUS_RDATA <= rdata_nxt;
      end
    end
  end

  // analog-side drive
  // the sampler tracks only in the sample phase and holds through the bit periods
  // booster follows its enable bit
  always_comb begin
    ANALOG_SEL = conv_chan_r;
    SAMPLE_EN  = (state_r == ST_SAMPLE);
    TAP_CODE   = sar_r;
    BOOSTER_EN = mode_r.booster;
    CONVERTING = (state_r == ST_SAMPLE) || (state_r == ST_CONVERT);
  end

endmodule // sar_adc_control
`default_nettype wire

// >>> verification/sar_adc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_chk
  import sar_adc_pkg::*;
(
  input wire logic        CLOCK,        // main clock
  input wire logic        RST_N,        // async reset
  input wire logic [15:0] BUS_ADDR,     // bus address
  input wire logic        BUS_WR,       // byte write
  input wire logic [7:0]  BUS_WDATA,    // write data
  input wire logic        BUS_RD,       // read strobe
  input wire logic [15:0] BUS_RDATA,    // read data
  input wire logic        BUS_RVALID,   // read valid
  input wire logic        SAMPLE_EN,    // sampler tracking
  input wire logic [2:0]  ANALOG_SEL,   // selected input
  input wire logic [9:0]  TAP_CODE,     // trial code
  input wire logic        BOOSTER_EN,   // booster on
  input wire logic        CONVERTING,   // busy
  input wire logic        CONV_DONE_IRQ // done pulse
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // control register write, which aborts a running conversion
  logic ctl_wr;
  assign ctl_wr = BUS_WR && (BUS_ADDR == ADDR_MODE || BUS_ADDR == ADDR_CHAN);
  // mode byte write, and the hold phase of a conversion
  logic mode_wr_c;
  logic holding;
  assign mode_wr_c = BUS_WR && BUS_ADDR == ADDR_MODE;
  assign holding   = CONVERTING && !SAMPLE_EN;

  a_irq_single_pulse: assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ)
    else $error("done pulse longer than one cycle");
  a_irq_in_convert: assert property (CONV_DONE_IRQ |-> CONVERTING && !SAMPLE_EN)
    else $error("done pulse outside conversion phase");
  a_idle_no_sample: assert property (!CONVERTING |-> !SAMPLE_EN)
    else $error("sampling while stopped");
  a_msb_trial_first: assert property ($fell(SAMPLE_EN) && CONVERTING |-> TAP_CODE == 10'h200)
    else $error("first trial code is not the top bit");
  a_sample_min_len: assert property ($fell(SAMPLE_EN) && CONVERTING |-> $past(SAMPLE_EN, 8))
    else $error("sample phase too short");
  a_sel_held: assert property (holding && $past(holding) |-> $stable(ANALOG_SEL))
    else $error("input selection moved during hold");
  a_stop_at_once: assert property (mode_wr_c && !BUS_WDATA[MODE_RUN_BIT] |=> !CONVERTING)
    else $error("conversion kept running after stop");
  a_abort_no_irq: assert property (ctl_wr && CONVERTING |=> !CONV_DONE_IRQ)
    else $error("done pulse after aborting write");
  a_write_beats_done: assert property (ctl_wr |-> !CONV_DONE_IRQ)
    else $error("done pulse in the cycle of a control write");
  a_booster_follows: assert property (mode_wr_c && BUS_WDATA[MODE_BOOSTER_BIT] |-> ##[1:2] BOOSTER_EN)
    else $error("booster not enabled");
  a_read_answer: assert property (BUS_RVALID == $past(BUS_RD))
    else $error("read valid not one cycle after strobe");
  a_result_pad_zero: assert property (BUS_RD && BUS_ADDR == ADDR_RESULT_LO |=> BUS_RDATA[5:0] == 6'h00)
    else $error("result low bits not zero");

  // main scenarios reached
  c_done: cover property (CONV_DONE_IRQ);
  c_abort: cover property (ctl_wr && CONVERTING);
  c_hold: cover property ($fell(SAMPLE_EN) && CONVERTING);
endmodule // sar_adc_chk

bind sar_adc_control sar_adc_chk sar_adc_chk_i (
  .CLOCK(CLOCK), .RST_N(RST_N), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR), .BUS_WDATA(BUS_WDATA),
  .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .BUS_RVALID(BUS_RVALID), .SAMPLE_EN(SAMPLE_EN),
  .ANALOG_SEL(ANALOG_SEL), .TAP_CODE(TAP_CODE), .BOOSTER_EN(BOOSTER_EN), .CONVERTING(CONVERTING),
  .CONV_DONE_IRQ(CONV_DONE_IRQ)
);
`default_nettype wire

// >>> verification/analog_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_src_model (
  input  wire logic        clk,       // main clock
  input  wire logic [79:0] levels,    // input n level at bits 10n+9..10n
  input  wire logic [2:0]  sel,       // selected input
  input  wire logic        sample_en, // track when high
  input  wire logic [9:0]  tap,       // trial code
  output logic             cmp        // input at or above tap
);
  logic [9:0] held_r;
  // track while sampling
  // later level changes must not reach the comparator
  always_ff @(posedge clk) begin
    if (sample_en)
      held_r <= levels[sel*10 +: 10];
  end
  assign cmp = (held_r >= tap);
endmodule // analog_src_model
`default_nettype wire

// >>> verification/sar_adc_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_bench
  import sar_adc_pkg::*;
;
  logic        CLOCK, RST_N, BUS_WR, BUS_BIT_WR, BUS_BIT_VAL, BUS_RD, EXT_TRIG_IN, cmp, hit;
  logic        SAMPLE_EN, BOOSTER_EN, CONVERTING, CONV_DONE_IRQ, BUS_RVALID;
  logic [15:0] BUS_ADDR, BUS_RDATA;
  logic [7:0]  BUS_WDATA;
  logic [2:0]  BUS_BIT_IDX, ANALOG_SEL;
  logic [9:0]  TAP_CODE, v, w;
  logic [79:0] levels;
  logic [2:0]  codes[4] = '{TIME_144, TIME_576, TIME_480, TIME_384};
  int          cycs[4] = '{CONV_CYC_144, CONV_CYC_576, CONV_CYC_480, CONV_CYC_384};
  logic [15:0] exp_q[$];
  int          fails, check_count, n;

  sar_adc_control sar_adc_control_i (.CLOCK(CLOCK), .RST_N(RST_N), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR),
    .BUS_WDATA(BUS_WDATA), .BUS_BIT_WR(BUS_BIT_WR), .BUS_BIT_IDX(BUS_BIT_IDX), .BUS_BIT_VAL(BUS_BIT_VAL),
    .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .BUS_RVALID(BUS_RVALID), .EXT_TRIG_IN(EXT_TRIG_IN),
    .CMP_IN(cmp), .ANALOG_SEL(ANALOG_SEL), .SAMPLE_EN(SAMPLE_EN), .TAP_CODE(TAP_CODE),
    .BOOSTER_EN(BOOSTER_EN), .CONVERTING(CONVERTING), .CONV_DONE_IRQ(CONV_DONE_IRQ));
  analog_src_model analog_src_model_i (.clk(CLOCK), .levels(levels), .sel(ANALOG_SEL),
    .sample_en(SAMPLE_EN), .tap(TAP_CODE), .cmp(cmp));

  // free-running main clock
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // byte write: held until the edge that takes it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    BUS_ADDR <= a;
    BUS_WDATA <= d;
    BUS_WR <= 1'b1;
    @(posedge CLOCK);
    BUS_WR <= 1'b0;
  endtask

  // read, then compare the answer one cycle later
  task automatic rc(input logic [15:0] a, input logic [15:0] e, input string what);
    @(posedge CLOCK);
    BUS_ADDR <= a;
    BUS_RD <= 1'b1;
    @(posedge CLOCK);
    BUS_RD <= 1'b0;
    #1;
    chk("read valid", {15'h0000, BUS_RVALID}, 16'h0001);
    chk(what, BUS_RDATA, e);
  endtask

  // bounded wait for the done pulse; a required one that never comes ends the run
  task automatic wait_irq(input int lim, input bit must, output int cnt, output logic got);
    cnt = 0;
    do begin
      @(posedge CLOCK);
      #1;
      cnt++;
    end while (cnt < lim && CONV_DONE_IRQ !== 1'b1);
    got = (CONV_DONE_IRQ === 1'b1);
    if (must && !got) begin
      chk("done pulse", {15'h0000, got}, 16'h0001);
      print_verdict();
    end
  endtask

  // run watchdog against a hung design
  initial begin
    repeat (100000) @(posedge CLOCK);
    fails++;
    print_verdict();
  end

  initial begin
    {RST_N, BUS_WR, BUS_BIT_WR, BUS_BIT_VAL, BUS_RD, EXT_TRIG_IN, BUS_ADDR, BUS_WDATA, BUS_BIT_IDX} = '0;
    levels = '0;
    void'($urandom(32'h2B42BDCC));
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    // reset values, unmapped read, booster bit write
    rc(ADDR_RESULT_LO, RESULT_RST, "result reset");
    rc(ADDR_MODE, 16'h0000, "mode reset");
    rc(ADDR_CHAN, 16'h0000, "chan reset");
    rc(16'hFF00, 16'h0000, "unmapped");
    @(posedge CLOCK);
    BUS_ADDR <= ADDR_MODE;
    BUS_BIT_IDX <= 3'h0;
    BUS_BIT_VAL <= 1'b1;
    BUS_BIT_WR <= 1'b1;
    @(posedge CLOCK);
    BUS_BIT_WR <= 1'b0;
    rc(ADDR_MODE, 16'h0001, "mode bit write");
    chk("booster", {15'h0000, BOOSTER_EN}, 16'h0001);
    // 14 us booster settling before run
    // settled booster, so first result counts
    repeat (1750) @(posedge CLOCK);
    $display("test reset done");
    // software start on every input, time codes 144, 576, 480 and 384
    for (int ch = 0; ch < 8; ch++) begin
      v = 10'($urandom);
      levels[ch*10 +: 10] = v;
      exp_q.push_back({v, 6'h00});
      wr(ADDR_CHAN, 8'(ch));
      wr(ADDR_MODE, {2'b10, codes[ch % 4], 2'b00, 1'b1});
      wait_irq(700, 1, n, hit);
      chk("first length", 16'(n), 16'(cycs[ch % 4] - 1));
      wait_irq(700, 1, n, hit);
      chk("repeat gap", 16'(n), 16'(cycs[ch % 4]));
      rc(ADDR_RESULT_LO, exp_q.pop_front(), "result");
      rc(ADDR_RESULT_HI, {8'h00, v[9:2]}, "high byte");
      // stop keeps the time code unchanged
      wr(ADDR_MODE, {2'b00, codes[ch % 4], 3'b001});
      @(posedge CLOCK);
      #1;
      chk("stopped", {15'h0000, CONVERTING}, 16'h0000);
    end
    $display("test software start done");
    // hold after sampling, abort by channel write
    v = 10'($urandom);
    w = ~v;
    levels[9:0] = v;
    levels[19:10] = w;
    wr(ADDR_CHAN, 8'h00);
    wr(ADDR_MODE, 8'h81);
    repeat (60) @(posedge CLOCK);
    levels[9:0] = w;
    wait_irq(200, 1, n, hit);
    rc(ADDR_RESULT_LO, {v, 6'h00}, "held level");
    repeat (40) @(posedge CLOCK);
    wr(ADDR_CHAN, 8'h01);
    wait_irq(200, 1, n, hit);
    chk("restart length", 16'(n), 16'(CONV_CYC_144 - 1));
    rc(ADDR_RESULT_LO, {w, 6'h00}, "new input");
    wr(ADDR_MODE, 8'h01);
    $display("test abort done");
    // hardware start: each edge code, rising then falling
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_MODE, {5'b11000, 2'(e), 1'b1});
      for (int k = 0; k < 2; k++) begin
        @(posedge CLOCK);
        EXT_TRIG_IN <= ~EXT_TRIG_IN;
        wait_irq(200, 0, n, hit);
        chk("trigger start", {15'h0000, hit}, {15'h0000, (k == 0) ? e[1] : e[0]});
        wait_irq(200, 0, n, hit);
        chk("single shot", {15'h0000, hit}, 16'h0000);
      end
    end
    // channel rewrite mid conversion waits for a new trigger
    wr(ADDR_MODE, 8'hC7);
    @(posedge CLOCK);
    EXT_TRIG_IN <= 1'b1;
    repeat (40) @(posedge CLOCK);
    wr(ADDR_CHAN, 8'h01);
    wait_irq(300, 0, n, hit);
    chk("suspended", {15'h0000, hit}, 16'h0000);
    @(posedge CLOCK);
    EXT_TRIG_IN <= 1'b0;
    wait_irq(200, 1, n, hit);
    rc(ADDR_RESULT_LO, {w, 6'h00}, "retriggered");
    wr(ADDR_MODE, 8'h07);
    wr(ADDR_MODE, 8'h00);
    $display("test hardware start done");
    // a mid-run reset clears a loaded result
    RST_N <= 1'b0;
    repeat (4) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    rc(ADDR_RESULT_LO, RESULT_RST, "result after reset");
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule // sar_adc_control_bench
`default_nettype wire
